// ===== rtl/char_video_pkg.sv
package char_video_pkg;
  localparam logic [7:0] SCROLL_PORT     = 8'hfe;
  localparam int         START_LSB       = 0;
  localparam int         POS_LSB         = 4;
  localparam int         FIELD_W         = 4;
  localparam int         STATUS_BIT      = 0;
  localparam int         CURSOR_BIT      = 7;
  localparam logic [6:0] SPACE_FLIP      = 7'h20;
  localparam logic [7:0] CHAR_RESET      = 8'h00;
  localparam logic [3:0] SCAN_PRESET     = 4'hf;
  localparam logic [3:0] SCAN_LAST       = 4'hb;
  localparam logic [3:0] BODY_LAST       = 4'h8;
  localparam logic [3:0] DESC_SHIFT      = 4'h3;
  localparam logic       PAD_DOT         = 1'b0;
  localparam logic       SERIAL_IN       = 1'b0;
  localparam logic       BLANK_LEVEL     = 1'b0;
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         WINDOW_NS       = 600;
  localparam int         WINDOW_CYC      = WINDOW_NS / CLK_PERIOD_NS;
  localparam logic [4:0] WINDOW_LOAD     = 5'(WINDOW_CYC);
  localparam int         TIMER_MS        = 250;
  localparam int         BLINK_PERIOD_MS = 500;
  localparam int         TIMER_CYC_DEF   =
    TIMER_MS * (1000000 / CLK_PERIOD_NS);
  localparam int         BLINK_CYC_DEF   =
    (BLINK_PERIOD_MS / 2) * (1000000 / CLK_PERIOD_NS);
  localparam int         CNT_W           = 24;
endpackage

// ===== rtl/glyph_rom.sv
`timescale 1ns/1ps
module glyph_rom (
  input  wire logic [6:0] code,
  input  wire logic [3:0] scan,
  output logic      [6:0] dots
);
  import char_video_pkg::*;

  // descender set: g j p q y , ;
  wire is_desc = (code == 7'h67) || (code == 7'h6a) || (code == 7'h70) ||
                 (code == 7'h71) || (code == 7'h79) || (code == 7'h2c) ||
                 (code == 7'h3b);
  wire printable = (code > 7'h20) && (code != 7'h7f);
  wire [3:0] line = is_desc ? 4'(scan - DESC_SHIFT) : scan;
  wire in_range = (scan <= SCAN_LAST) && (!is_desc || scan >= DESC_SHIFT);
  wire in_body = printable && in_range && (line <= BODY_LAST);

  // compact font: two sample glyphs, others a framed cell
  function automatic logic [6:0] body_row(input logic [6:0] c,
                                          input logic [3:0] l);
    logic edge_row;
    edge_row = (l == 4'h0) || (l == BODY_LAST);
    unique case (c)
      7'h43: body_row = edge_row ? 7'h1e : 7'h41;
      7'h54: body_row = (l == 4'h0) ? 7'h7f : 7'h08;
      default: body_row = edge_row ? 7'h7f : 7'h41;
    endcase
  endfunction

  // index fifteen and spare lines stay blank
  assign dots = in_body ? body_row(code, line) : 7'h00;
endmodule

// ===== rtl/char_video_scroll_gen.sv
`timescale 1ns/1ps
module char_video_scroll_gen #(
  parameter int unsigned TIMER_CYCLES = char_video_pkg::TIMER_CYC_DEF,
  parameter int unsigned BLINK_CYCLES = char_video_pkg::BLINK_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load_strobe,
  input  wire logic       line_end,
  input  wire logic       vertical_display_active,
  input  wire logic       comp_blank,
  input  wire logic       display_page_select,
  input  wire logic [9:0] bus_addr,
  input  wire logic [5:0] char_col,
  input  wire logic [7:0] mem_data,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] bus_data_in,
  input  wire logic       reverse_video_switch,
  input  wire logic       cursor_flash_switch,
  output logic            video_q,
  output logic      [9:0] mem_addr_q,
  output logic      [3:0] scan_line_q,
  output logic      [7:0] bus_data_out_q,
  output logic            bus_oe_n_q,
  output logic            top_shade_q,
  output logic            scroll_busy_q
);
  import char_video_pkg::*;

  if (TIMER_CYCLES < 2 || TIMER_CYCLES >= (1 << CNT_W)) begin : g_chk_t
    $error("TIMER_CYCLES out of range");
  end
  if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (1 << CNT_W)) begin : g_chk_b
    $error("BLINK_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] TIMER_LOAD = CNT_W'(TIMER_CYCLES);
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYCLES - 1);

  logic [7:0]       char_q;
  logic [7:0]       sh_q;
  logic             cursor_q;
  logic [1:0]       blank_dly_q;
  logic [CNT_W-1:0] blink_cnt_q;
  logic             blink_q;
  logic [4:0]       win_q;
  logic [3:0]       start_q;
  logic [3:0]       pos_preset_q;
  logic [3:0]       row_start_q;
  logic [3:0]       pos_q;
  logic [CNT_W-1:0] timer_q;
  logic [6:0]       glyph_dots;

  // port decode
  wire scroll_port_write = io_wr && (io_addr == SCROLL_PORT);
  wire scroll_port_read  = io_rd && (io_addr == SCROLL_PORT);

  // latch holds the code with the space bit flipped, so clear means space
  wire [6:0] glyph_code = char_q[6:0] ^ SPACE_FLIP;
  wire       row_end    = line_end && (scan_line_q == SCAN_LAST);
  wire       row_adv    = (win_q == 5'h01);
  wire       pos_tc     = (pos_q == 4'h0);
  wire       cursor_on  = cursor_q && (!cursor_flash_switch || blink_q);
  wire       cursor_dot = sh_q[7] ^ cursor_on;
  wire       blanked    = top_shade_q || blank_dly_q[1];
  wire       shown_dot  = blanked ? BLANK_LEVEL : cursor_dot;
  wire       video_d    = shown_dot ^ reverse_video_switch;
  wire       timer_on   = timer_q > CNT_W'(1);
  wire [9:0] scan_addr  = {row_start_q, char_col};
  wire [9:0] mem_addr_d = display_page_select ? bus_addr : scan_addr;

  glyph_rom u_glyph (
    .code (glyph_code),
    .scan (scan_line_q),
    .dots (glyph_dots)
  );

  // character latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      char_q <= CHAR_RESET;
    end else if (display_page_select) begin
      char_q <= CHAR_RESET;
    end else if (load_strobe) begin
      char_q <= {mem_data[CURSOR_BIT], mem_data[6:0] ^ SPACE_FLIP};
    end
  end

  // serializer, cursor latch and blanking delay share the load strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q        <= 8'h00;
      cursor_q    <= 1'b0;
      blank_dly_q <= 2'b11;
    end else if (load_strobe) begin
      sh_q        <= {PAD_DOT, glyph_dots};
      cursor_q    <= char_q[CURSOR_BIT];
      blank_dly_q <= {blank_dly_q[0], comp_blank};
    end else begin
      sh_q        <= {sh_q[6:0], SERIAL_IN};
    end
  end

  // free-running blink
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == BLINK_LAST) begin
      blink_cnt_q <= '0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + CNT_W'(1);
    end
  end

  // scan line counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_line_q <= SCAN_PRESET;
    end else if (row_end) begin
      scan_line_q <= SCAN_PRESET;
    end else if (line_end) begin
      scan_line_q <= scan_line_q + 4'h1;
    end
  end

  // advance window after each row end; counters step as it closes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_q <= 5'h00;
    end else if (row_end) begin
      win_q <= WINDOW_LOAD;
    end else if (win_q != 5'h00) begin
      win_q <= win_q - 5'h01;
    end
  end

  // scroll latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_q      <= 4'h0;
      pos_preset_q <= 4'h0;
    end else if (scroll_port_write) begin
      start_q      <= bus_data_in[START_LSB +: FIELD_W];
      pos_preset_q <= bus_data_in[POS_LSB +: FIELD_W];
    end
  end

  // row start and screen position counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_start_q <= 4'h0;
      pos_q       <= 4'h0;
    end else if (!vertical_display_active) begin
      row_start_q <= start_q;
      pos_q       <= pos_preset_q;
    end else if (row_adv) begin
      if (!pos_tc) begin
        pos_q <= pos_q - 4'h1;
      end
      if (!top_shade_q) begin
        row_start_q <= row_start_q + 4'h1;
      end
    end
  end

  // window shade
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      top_shade_q <= 1'b1;
    end else if (!vertical_display_active) begin
      top_shade_q <= 1'b1;
    end else if (pos_tc) begin
      top_shade_q <= 1'b0;
    end
  end

  // scroll pacing timer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_q       <= '0;
      scroll_busy_q <= 1'b0;
    end else if (scroll_port_write) begin
      timer_q       <= TIMER_LOAD;
      scroll_busy_q <= 1'b1;
    end else begin
      if (timer_q != '0) begin
        timer_q <= timer_q - CNT_W'(1);
      end
      scroll_busy_q <= timer_on;
    end
  end

  // status read and output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_oe_n_q     <= 1'b1;
      bus_data_out_q <= 8'h00;
      video_q        <= 1'b0;
      mem_addr_q     <= 10'h000;
    end else begin
      bus_oe_n_q     <= !scroll_port_read;
      bus_data_out_q <= 8'h00;
      bus_data_out_q[STATUS_BIT] <= scroll_port_read && scroll_busy_q;
      video_q        <= video_d;
      mem_addr_q     <= mem_addr_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  latch_clear_a: assert property (
    display_page_select |=> char_q == CHAR_RESET)
    else $error("latch not cleared on page select");
  latch_load_a: assert property (
    load_strobe && !display_page_select
    |=> char_q[6:0] == ($past(mem_data[6:0]) ^ SPACE_FLIP)
        && char_q[7] == $past(mem_data[7]))
    else $error("character latch load wrong");
  blank_line_a: assert property (
    scan_line_q == SCAN_PRESET |-> glyph_dots == 7'h00)
    else $error("spacer line not blank");
  scan_wrap_a: assert property (
    row_end |=> scan_line_q == SCAN_PRESET)
    else $error("scan counter did not reload");
  spacer_dots_a: assert property (
    load_strobe ##1 !load_strobe [*8] |=> sh_q[7] == PAD_DOT)
    else $error("serial spacer dot missing");
  lead_dot_a: assert property (
    load_strobe |=> sh_q[7] == PAD_DOT && sh_q[6:0] == $past(glyph_dots))
    else $error("serializer parallel load wrong");
  shade_out_a: assert property (
    top_shade_q |=> video_q == $past(reverse_video_switch))
    else $error("shaded video not blank");
  scroll_latch_a: assert property (
    scroll_port_write |=> pos_preset_q == $past(bus_data_in[7:4])
                          && start_q == $past(bus_data_in[3:0]))
    else $error("scroll latch wrong");
  vblank_hold_a: assert property (
    !vertical_display_active
    |=> pos_q == $past(pos_preset_q) && row_start_q == $past(start_q)
        && top_shade_q)
    else $error("counters not held preset");
  shade_end_a: assert property (
    vertical_display_active && pos_tc |=> !top_shade_q)
    else $error("shade did not end at zero");
  window_a: assert property (
    row_end && vertical_display_active ##1 vertical_display_active [*8]
    |-> !row_adv ##[1:7] row_adv)
    else $error("row advance window wrong");
  timer_busy_a: assert property (
    scroll_port_write |=> scroll_busy_q [*8])
    else $error("scroll timer not started");
  status_read_a: assert property (
    scroll_port_read
    |=> !bus_oe_n_q && bus_data_out_q[STATUS_BIT] == $past(scroll_busy_q))
    else $error("status read wrong");
  cursor_steady_a: assert property (
    cursor_q && !cursor_flash_switch && !blanked
    |=> video_q == !($past(sh_q[7]) ^ $past(reverse_video_switch)))
    else $error("steady cursor not inverted");

  scroll_write_c: cover property (scroll_port_write ##1 scroll_busy_q);
  cursor_show_c:  cover property (cursor_on && !blanked);
  row_step_c:     cover property (row_adv && !top_shade_q);
  shade_drop_c:   cover property (top_shade_q ##1 !top_shade_q);
endmodule

// ===== verification/display_mem_model.sv
`timescale 1ns/1ps
module display_mem_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] word,
  output logic            load_strobe,
  output logic      [7:0] mem_data
);
  logic [3:0] dot_q;

  // one load strobe every nine dots: seven glyph dots and two spacers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dot_q <= 4'h0;
    end else begin
      dot_q <= (dot_q == 4'h8) ? 4'h0 : dot_q + 4'h1;
    end
  end

  assign load_strobe = (dot_q == 4'h8);
  // every cell holds the same word, so each character time repeats
  assign mem_data    = word;
endmodule

// ===== verification/char_video_scroll_gen_tb.sv
`timescale 1ns/1ps
module char_video_scroll_gen_tb;
  import char_video_pkg::*;
  logic       clk         = 1'b0;
  logic       rst         = 1'b1;
  logic       line_end    = 1'b0;
  logic       vda         = 1'b0;
  logic       comp_blank  = 1'b0;
  logic       page_sel    = 1'b0;
  logic       io_wr       = 1'b0;
  logic       io_rd       = 1'b0;
  logic       rev         = 1'b0;
  logic       flash       = 1'b0;
  logic [9:0] bus_addr    = 10'h2a5;
  logic [5:0] char_col    = 6'h15;
  logic [7:0] io_addr     = 8'h00;
  logic [7:0] bus_data_in = 8'h00;
  logic [7:0] word        = 8'ha0;
  logic       load_strobe;
  logic [7:0] mem_data;
  logic       video_q;
  logic       bus_oe_n_q;
  logic       top_shade_q;
  logic       scroll_busy_q;
  logic [9:0] mem_addr_q;
  logic [3:0] scan_line_q;
  logic [7:0] bus_data_out_q;
  int         n_errors    = 0;
  int         checks      = 0;
  int         ones;

  always #20 clk = ~clk;

  display_mem_model u_mem (.clk(clk), .rst(rst), .word(word),
    .load_strobe(load_strobe), .mem_data(mem_data));

  char_video_scroll_gen #(.TIMER_CYCLES(20), .BLINK_CYCLES(8)) u_dut (
    .clk(clk), .rst(rst), .load_strobe(load_strobe), .line_end(line_end),
    .vertical_display_active(vda), .comp_blank(comp_blank),
    .display_page_select(page_sel), .bus_addr(bus_addr),
    .char_col(char_col), .mem_data(mem_data), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .bus_data_in(bus_data_in),
    .reverse_video_switch(rev), .cursor_flash_switch(flash),
    .video_q(video_q), .mem_addr_q(mem_addr_q), .scan_line_q(scan_line_q),
    .bus_data_out_q(bus_data_out_q), .bus_oe_n_q(bus_oe_n_q),
    .top_shade_q(top_shade_q), .scroll_busy_q(scroll_busy_q));

  task automatic chk(input string name, input logic [9:0] seen,
                     input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // waits n edges, then steps past the edge so outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic io_write(input logic [7:0] d);
    @(posedge clk);
    io_addr     <= SCROLL_PORT;
    bus_data_in <= d;
    io_wr       <= 1'b1;
    @(posedge clk);
    io_wr       <= 1'b0;
  endtask

  task automatic io_read(input logic [7:0] a, input logic [7:0] exp,
                         input logic oe_n);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd   <= 1'b0;
    #1;
    chk("oe_n", bus_oe_n_q, oe_n);
    if (!oe_n) chk("rd_data", bus_data_out_q, exp);
  endtask

  // one scan line step, then the nine dots of one character time
  task automatic glyph_line(input logic [8:0] exp);
    @(posedge clk);
    line_end <= 1'b1;
    @(posedge clk);
    line_end <= 1'b0;
    tick(20);
    @(posedge clk iff load_strobe);
    for (int i = 8; i >= 0; i--) begin
      tick(1);
      chk("dot", video_q, exp[i]);
    end
  endtask

  // the stream repeats each character, so every dot should match
  task automatic dots(input logic exp);
    tick(40);
    repeat (9) begin
      tick(1);
      chk("video", video_q, exp);
    end
  endtask

  // n character rows of thirteen scan lines each
  task automatic rows(input int n);
    repeat (n) begin
      for (int i = 0; i < 13; i++) begin
        @(posedge clk);
        line_end <= 1'b1;
        @(posedge clk);
        line_end <= 1'b0;
        tick(18);
        chk("scan", scan_line_q, (i == 12) ? 10'hf : 10'(i));
      end
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("scan_rst", scan_line_q, 10'hf);
    chk("busy_rst", scroll_busy_q, 10'h0);
    dots(1'b0);
    @(posedge clk) rev <= 1'b1;
    dots(1'b1);
    @(posedge clk) begin rev <= 1'b0; vda <= 1'b1; end
    tick(5);
    chk("shade", top_shade_q, 10'h0);
    dots(1'b1);
    @(posedge clk) rev <= 1'b1;
    dots(1'b0);
    @(posedge clk) begin rev <= 1'b0; comp_blank <= 1'b1; end
    dots(1'b0);
    @(posedge clk) begin comp_blank <= 1'b0; page_sel <= 1'b1; end
    dots(1'b0);
    chk("addr_bus", mem_addr_q, bus_addr);
    @(posedge clk) page_sel <= 1'b0;
    tick(2);
    chk("addr_scan", mem_addr_q, {4'h0, char_col});
    @(posedge clk) word <= 8'h20;
    dots(1'b0);
    @(posedge clk) begin word <= 8'ha0; flash <= 1'b1; end
    tick(40);
    ones = 0;
    repeat (32) begin
      tick(1);
      ones += int'(video_q === 1'b1);
    end
    chk("blink", 10'(ones > 0 && ones < 32), 10'h1);
    @(posedge clk) begin flash <= 1'b0; vda <= 1'b0; end
    io_write(8'h23);
    tick(1);
    chk("busy", scroll_busy_q, 10'h1);
    tick(3);
    chk("start", mem_addr_q[9:6], 10'h3);
    chk("shade", top_shade_q, 10'h1);
    io_read(SCROLL_PORT, 8'h01, 1'b0);
    io_read(8'hfd, 8'h00, 1'b1);
    io_write(8'h23);
    tick(19);
    chk("busy", scroll_busy_q, 10'h1);
    tick(1);
    chk("busy", scroll_busy_q, 10'h0);
    io_read(SCROLL_PORT, 8'h00, 1'b0);
    @(posedge clk) vda <= 1'b1;
    rows(1);
    chk("shade", top_shade_q, 10'h1);
    chk("start", mem_addr_q[9:6], 10'h3);
    rows(1);
    chk("shade", top_shade_q, 10'h0);
    rows(1);
    chk("start", mem_addr_q[9:6], 10'h4);
    @(posedge clk) word <= 8'h54;
    glyph_line(9'h0fe);
    glyph_line(9'h010);
    @(posedge clk) vda <= 1'b0;
    tick(3);
    chk("start", mem_addr_q[9:6], 10'h3);
    chk("shade", top_shade_q, 10'h1);
    give_verdict();
  end
endmodule
